// *** hw/nsr_params.svh ***
// constants for the nand status, id and reset controller
`ifndef NSR_PARAMS_SVH
`define NSR_PARAMS_SVH
`define NSR_CMD_READ1 8'h00
`define NSR_CMD_READ3 8'h50
`define NSR_CMD_STATUS 8'h70
`define NSR_CMD_MSTATUS 8'h71
`define NSR_CMD_ID 8'h90
`define NSR_CMD_RESET 8'hFF
`define NSR_CMD_PROG 8'h10
`define NSR_CMD_ERASE 8'hD0
`define NSR_ID_ADDR 8'h00
// maker and device codes: arbitrary values
`define NSR_ID_MAKER 8'h3C
`define NSR_ID_DEVICE 8'h5A
`define NSR_ID_RSVD 8'hA5
`define NSR_ID_CAPAB 8'hC0
`define NSR_STATUS_RESET 8'hC0
`define NSR_BIT_FAIL 0
`define NSR_BIT_PLANE0 1
`define NSR_BIT_READY 6
`define NSR_BIT_NWP 7
`define NSR_CLK_MHZ 200
`define NSR_RST_NS 5000
`define NSR_RST_CYC ((`NSR_RST_NS * `NSR_CLK_MHZ) / 1000)
`define NSR_PWR_US 10
`define NSR_PWR_CYC (`NSR_PWR_US * `NSR_CLK_MHZ)
`endif

// *** hw/nsr_pkg.sv ***
// types for the nand status, id and reset controller
package nsr_pkg;
	typedef enum logic [4:0] {
		NSR_M_READ = 5'h01,
		NSR_M_STATUS = 5'h02,
		NSR_M_MSTATUS = 5'h04,
		NSR_M_ID = 5'h08,
		NSR_M_IDLE = 5'h10
	} nsr_mode_t;
	typedef struct packed {
		logic busy;
		logic fail;
		logic [3:0] plane_fail;
	} nsr_core_t;
endpackage

// *** hw/nsr_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module nsr_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} nsr_sync_st_t;
	nsr_sync_st_t st;
	nsr_sync_st_t next_st;
	always_comb begin
		next_st.s1 = d;
		next_st.s2 = st.s1;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			// preload pin levels so no false strobe edge follows reset
			st.s1 <= d;
			st.s2 <= d;
		end else begin
			st <= next_st;
		end
	end
	assign q = st.s2;
endmodule

// *** hw/nsr_ctrl.sv ***
// nand status, id, reset and ready/busy control
// Behaviour
// - status byte driven on reads, launched by later of select or output strobe
// - status byte driven keeps tracking live state without strobe toggling
// - status mode held until next command; host reissues read before page reads
// - multi-plane status command reports per-plane results
// - bit 0 is 0 pass, 1 fail; any failing plane sets it
// - bits 1..4 give plane 0..3 fail under multi-plane status
// - bit 6 is 0 busy, 1 ready; bit 5 reserved
// - bit 7 is 0 protected, 1 not protected
// - id command plus zero address; four reads: maker, device, reserved, capability
// - third id byte reserved; fourth byte C0 means multi-plane support
// - id mode held until next command
// - reset aborts busy read, program or erase
// - reset clears decoder; clears status to C0 with write protect high
// - reset ignored while already in reset state
// - ready/busy low for reset recovery then high
// - ready/busy low during program, erase or random read
// - ready/busy is open drain
// - power-up starts in read mode; after reset waits for command
`timescale 1ns/10ps
`include "nsr_params.svh"
module nsr_ctrl #(
	parameter int RST_CYC = `NSR_RST_CYC,
	parameter int PWR_CYC = `NSR_PWR_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic chip_sel_n,
	input wire logic cmd_latch,
	input wire logic addr_latch,
	input wire logic write_strobe_n,
	input wire logic output_strobe_n,
	input wire logic write_prot_n,
	input wire logic [7:0] io_in,
	input wire nsr_pkg::nsr_core_t core,
	output logic [7:0] io_out,
	output logic io_oe,
	output logic ready_busy_out,
	output logic ready_busy_oe,
	output logic core_abort,
	output logic core_start
);
	// ------------------------------------------------------------
	// pin synchronisation
	// ------------------------------------------------------------
	logic [13:0] pin_q;
	nsr_sync #(.W(14)) u_sync (
		.clk(clk),
		.rst(rst),
		.d({chip_sel_n, cmd_latch, addr_latch, write_strobe_n, output_strobe_n,
			write_prot_n, io_in}),
		.q(pin_q)
	);
	logic ce_n;
	logic cle;
	logic ale;
	logic we_n;
	logic oe_n;
	logic wp_n;
	logic [7:0] din;
	assign {ce_n, cle, ale, we_n, oe_n, wp_n, din} = pin_q;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		nsr_pkg::nsr_mode_t mode;
		logic we_d;
		logic rd_d;
		logic id_armed;
		logic [1:0] id_idx;
		logic [7:0] stat;
		logic [3:0] plane;
		logic fail;
		logic reset_state;
		logic [15:0] rst_cnt;
		logic [11:0] pwr_cnt;
		logic prog_busy;
		logic [7:0] io_out;
		logic io_oe;
		logic rb_low;
		logic abort;
		logic start;
	} nsr_st_t;
	nsr_st_t st;
	nsr_st_t next_st;

	logic wr_edge;
	logic rd_fall;
	logic rd_rise;
	logic busy_all;
	logic [7:0] live_stat;
	logic [7:0] id_byte;

	always_comb begin
		wr_edge = !ce_n && we_n && !st.we_d;
		rd_fall = !(ce_n || oe_n) && st.rd_d;
		rd_rise = (ce_n || oe_n) && !st.rd_d;
		busy_all = core.busy || st.rst_cnt != 16'h0000 || st.pwr_cnt != 12'h000;
		live_stat = 8'h00;
		live_stat[`NSR_BIT_FAIL] = st.fail;
		live_stat[`NSR_BIT_READY] = !busy_all;
		live_stat[`NSR_BIT_NWP] = wp_n;
		if (st.mode == nsr_pkg::NSR_M_MSTATUS) begin
			live_stat[4:1] = st.plane;
		end
		unique case (st.id_idx)
			2'd0: id_byte = `NSR_ID_MAKER;
			2'd1: id_byte = `NSR_ID_DEVICE;
			2'd2: id_byte = `NSR_ID_RSVD;
			2'd3: id_byte = `NSR_ID_CAPAB;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.we_d = we_n;
		next_st.rd_d = ce_n || oe_n;
		next_st.abort = 1'b0;
		next_st.start = 1'b0;
		if (st.pwr_cnt != 12'h000) begin
			next_st.pwr_cnt = st.pwr_cnt - 12'h001;
		end
		if (st.rst_cnt != 16'h0000) begin
			next_st.rst_cnt = st.rst_cnt - 16'h0001;
		end
		if (st.prog_busy && !core.busy) begin
			next_st.prog_busy = 1'b0;
			next_st.plane = core.plane_fail;
			next_st.fail = |core.plane_fail;
		end
		if (wr_edge && cle) begin
			if (din == `NSR_CMD_RESET) begin
				if (!st.reset_state) begin
					next_st.abort = core.busy;
					next_st.prog_busy = 1'b0;
					next_st.mode = nsr_pkg::NSR_M_IDLE;
					next_st.id_armed = 1'b0;
					next_st.reset_state = 1'b1;
					next_st.rst_cnt = 16'(RST_CYC);
					if (wp_n) begin
						next_st.fail = 1'b0;
						next_st.plane = 4'h0;
					end
				end
			end else begin
				next_st.reset_state = 1'b0;
				next_st.id_armed = 1'b0;
				unique case (din)
					`NSR_CMD_STATUS: next_st.mode = nsr_pkg::NSR_M_STATUS;
					`NSR_CMD_MSTATUS: next_st.mode = nsr_pkg::NSR_M_MSTATUS;
					`NSR_CMD_ID: begin
						next_st.mode = nsr_pkg::NSR_M_ID;
						next_st.id_armed = 1'b1;
						next_st.id_idx = 2'd0;
					end
					`NSR_CMD_PROG, `NSR_CMD_ERASE: begin
						next_st.start = 1'b1;
						next_st.prog_busy = 1'b1;
						next_st.mode = nsr_pkg::NSR_M_READ;
					end
					default: next_st.mode = nsr_pkg::NSR_M_READ;
				endcase
			end
		end else if (wr_edge && ale && st.id_armed && din == `NSR_ID_ADDR) begin
			next_st.id_idx = 2'd0;
			next_st.id_armed = 1'b0;
		end
		if (rd_rise && st.mode == nsr_pkg::NSR_M_ID) begin
			next_st.id_idx = st.id_idx + 2'd1;
		end
		next_st.io_oe = !(ce_n || oe_n) && (st.mode != nsr_pkg::NSR_M_READ)
			&& (st.mode != nsr_pkg::NSR_M_IDLE);
		if (st.mode == nsr_pkg::NSR_M_ID) begin
			next_st.io_out = id_byte;
		end else begin
			next_st.io_out = live_stat;
		end
		if (rd_fall) begin
			next_st.io_out = next_st.io_out;
		end
		next_st.stat = live_stat;
		next_st.rb_low = core.busy || next_st.rst_cnt != 16'h0000
			|| next_st.prog_busy;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
			st.mode <= nsr_pkg::NSR_M_READ;
			st.we_d <= 1'b1;
			st.rd_d <= 1'b1;
			st.pwr_cnt <= 12'(PWR_CYC);
			st.stat <= `NSR_STATUS_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign io_out = st.io_out;
	assign io_oe = st.io_oe;
	assign ready_busy_out = 1'b0;
	assign ready_busy_oe = st.rb_low;
	assign core_abort = st.abort;
	assign core_start = st.start;
endmodule

// *** sim/nsr_ctrl_properties.sv ***
// port assertions for the nand status controller
`timescale 1ns/10ps
module nsr_ctrl_properties (
	input wire logic clk,
	input wire logic rst,
	input wire logic chip_sel_n,
	input wire logic output_strobe_n,
	input wire nsr_pkg::nsr_core_t core,
	input wire logic io_oe,
	input wire logic ready_busy_out,
	input wire logic ready_busy_oe,
	input wire logic core_abort,
	input wire logic core_start
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_rb_open: assert property (!ready_busy_out) else $error("rb high");
	a_reset_quiet: assert property ($fell(rst) |-> !io_oe && !ready_busy_oe)
		else $error("active after reset");
	a_abort_cause: assert property (core_abort |-> $past(core.busy))
		else $error("abort while idle");
	a_abort_pulse: assert property (core_abort |=> !core_abort) else $error("abort long");
	a_start_pulse: assert property (core_start |=> !core_start) else $error("start long");
	a_start_busy: assert property (core_start |-> ##[1:6] ready_busy_oe)
		else $error("no busy after start");
	a_rb_width: assert property ($rose(ready_busy_oe) |-> ready_busy_oe[*4] ##[1:40] !ready_busy_oe)
		else $error("busy width");
	a_oe_strobe: assert property (output_strobe_n[*5] |-> !io_oe) else $error("oe no strobe");
	a_oe_select: assert property (chip_sel_n[*5] |-> !io_oe) else $error("oe no select");
	c_abort: cover property (core_abort);
	c_start: cover property (core_start);
	c_read: cover property (io_oe);
endmodule

// *** sim/nsr_host_model.sv ***
// host controller pin model
`timescale 1ns/10ps
module nsr_host_model (
	input wire logic clk,
	output logic chip_sel_n = 1'b1,
	output logic cmd_latch = 1'b0,
	output logic addr_latch = 1'b0,
	output logic write_strobe_n = 1'b1,
	output logic output_strobe_n = 1'b1,
	output logic [7:0] io_in = 8'h00
);
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	// strobes held 4 cycles each side
	task automatic wr(input logic cle, input logic [7:0] b);
		chip_sel_n = 1'b0;
		cmd_latch = cle;
		addr_latch = !cle;
		io_in = b;
		write_strobe_n = 1'b0;
		idle(4);
		write_strobe_n = 1'b1;
		idle(4);
		cmd_latch = 1'b0;
		addr_latch = 1'b0;
		chip_sel_n = 1'b1;
		io_in = ~b;
	endtask
	// select and output strobe move together; select released between transfers
	task automatic rd(input logic lvl);
		chip_sel_n = lvl;
		output_strobe_n = lvl;
		idle(6);
	endtask
endmodule

// *** sim/nsr_ctrl_tb.sv ***
// self-checking bench for the nand status controller
`timescale 1ns/10ps
module nsr_ctrl_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic write_prot_n = 1'b0;
	logic hold = 1'b0;
	logic rb_q = 1'b0;
	logic [4:0] pf = 5'h00;
	logic [7:0] io_out;
	logic io_oe, rb_out, rb_oe, abort, start;
	wire cs_n, cle, ale, we_n, re_n;
	wire [7:0] io_in;
	int cnt = 0;
	int rises = 0;
	int err_total = 0;
	int samples_checked = 0;
	nsr_pkg::nsr_core_t core;
	assign core = {hold || cnt != 0, pf};
	initial forever #2.5 clk = ~clk;
	always @(negedge clk) cnt <= abort ? 0 : start ? 12 : cnt > 0 ? cnt - 1 : 0;
	always @(posedge clk) begin
		rb_q <= rb_oe;
		if (rb_oe && !rb_q) rises++;
	end
	nsr_host_model h (.clk(clk), .chip_sel_n(cs_n), .cmd_latch(cle), .addr_latch(ale),
		.write_strobe_n(we_n), .output_strobe_n(re_n), .io_in(io_in));
	nsr_ctrl #(.RST_CYC(4), .PWR_CYC(8)) DUT (.clk(clk), .rst(rst), .chip_sel_n(cs_n),
		.cmd_latch(cle), .addr_latch(ale), .write_strobe_n(we_n), .output_strobe_n(re_n),
		.write_prot_n(write_prot_n), .io_in(io_in), .core(core), .io_out(io_out),
		.io_oe(io_oe), .ready_busy_out(rb_out), .ready_busy_oe(rb_oe),
		.core_abort(abort), .core_start(start));
	task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic rdb(input logic [7:0] e);
		h.rd(1'b0);
		chk("io", e, io_oe === 1'b1 ? io_out : 8'hXX);
		h.rd(1'b1);
	endtask
	task automatic results();
		$display("compares %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic wait_ready();
		int n;
		for (n = 0; n < 100 && rb_oe !== 1'b0; n++) h.idle(1);
		if (n == 100) begin
			err_total++;
			$display("mismatch ready_busy expected 0 seen 1");
			results();
		end
	endtask
	task automatic t_status();
		h.wr(1'b1, 8'h70);
		rdb(8'hC0);
		write_prot_n = 1'b0;
		rdb(8'h40);
		write_prot_n = 1'b1;
		h.rd(1'b0);
		hold = 1'b1;
		h.idle(6);
		chk("live", 8'h80, io_out);
		hold = 1'b0;
		h.idle(6);
		chk("live", 8'hC0, io_out);
		h.rd(1'b1);
	endtask
	task automatic t_id();
		logic [7:0] ids [5] = '{`NSR_ID_MAKER, `NSR_ID_DEVICE, 8'hA5, 8'hC0, `NSR_ID_MAKER};
		h.wr(1'b1, 8'h90);
		h.wr(1'b0, 8'h00);
		foreach (ids[i]) rdb(ids[i]);
	endtask
	task automatic t_multi();
		pf = 5'b10101;
		h.wr(1'b1, 8'h10);
		chk("rb", 8'h01, {7'h00, rb_oe});
		wait_ready();
		h.wr(1'b1, 8'h71);
		rdb(8'hCB);
		h.wr(1'b1, 8'h70);
		rdb(8'hC1);
	endtask
	task automatic t_reset();
		int r;
		hold = 1'b1;
		h.wr(1'b1, 8'hFF);
		hold = 1'b0;
		wait_ready();
		r = rises;
		h.wr(1'b1, 8'hFF);
		h.idle(4);
		chk("rb_rises", 8'h00, 8'(rises - r));
		h.wr(1'b1, 8'h70);
		rdb(8'hC0);
	endtask
	initial begin
		repeat (3) @(negedge clk);
		rst = 1'b0;
		h.idle(12);
		write_prot_n = 1'b1;
		t_status();
		t_id();
		t_multi();
		t_reset();
		results();
	end
endmodule
bind nsr_ctrl nsr_ctrl_properties u_props (.clk(clk), .rst(rst), .chip_sel_n(chip_sel_n),
	.output_strobe_n(output_strobe_n), .core(core), .io_oe(io_oe),
	.ready_busy_out(ready_busy_out), .ready_busy_oe(ready_busy_oe),
	.core_abort(core_abort), .core_start(core_start));
